//--- verilog/grant_sched_map.svh
// register offsets, field positions, reset values and fixed counts of the grant scheduler
// assumes an 8-bit apb byte address; every register is one aligned 32-bit word
`ifndef GRANT_SCHED_MAP_SVH
`define GRANT_SCHED_MAP_SVH
`define GS_CTRL_ADDR       8'h00
`define GS_GRANT_CFG_ADDR  8'h04
`define GS_GRANT_IVL_ADDR  8'h08
`define GS_POLL_IVL_ADDR   8'h0c
`define GS_IDLE_LIMIT_ADDR 8'h10
`define GS_STATUS_ADDR     8'h14
`define GS_FLOW_SEL_ADDR   8'h18
`define GS_FLOW_REC_ADDR   8'h1c
`define GS_CTRL_EN_BIT     0
`define GS_CTRL_MODE_LSB   1
`define GS_CTRL_FLOW_LSB   4
`define GS_GCFG_GPI_LSB    16
`define GS_HDR_QI_BIT      7
`define GS_GRANT_SIZE_RST  16'h0000
`define GS_GPI_RST         7'h01
`define GS_IVL_RST         24'h0003e8
`define GS_IDLE_RST        8'h04
`define GS_PCT_DEN         8'h64
`define GS_POLICY_NO_REQ   3'h7
`endif

//--- verilog/grant_sched_pkg.sv
// types shared by the grant scheduler and its per-flow record memory
// assumes nothing of its surroundings
package grant_sched_pkg;
  typedef enum logic [1:0] {
    fixed_grant_mode,
    realtime_poll_mode,
    activity_detect_grant_mode,
    nonrealtime_poll_mode
  } sched_mode_t;
  typedef enum logic {phase_inactive, phase_active} flow_phase_t;
  typedef struct packed {
    sched_mode_t mode;
    flow_phase_t phase;
    logic        qi;
    logic [6:0]  count;
  } flow_rec_t;
endpackage

//--- verilog/flow_rec_mem.sv
// per-flow record memory: one write port, one registered read port
// assumes writer and reader share ref_clk_in; read data lag the address by one edge
`timescale 1ns/100ps
module flow_rec_mem #(
  parameter int FLOWS = 4,
  parameter int FW    = 2
) (
  input  wire logic                      ref_clk_in,
  input  wire logic                      reset_in,
  input  wire logic                      wr_en_in,
  input  wire logic [FW-1:0]             wr_addr_in,
  input  wire grant_sched_pkg::flow_rec_t wr_data_in,
  input  wire logic [FW-1:0]             rd_addr_in,
  output grant_sched_pkg::flow_rec_t     rd_data_out
);
  import grant_sched_pkg::*;
  flow_rec_t mem [FLOWS];

  initial begin
    if (FLOWS != (1 << FW)) $error("FLOWS must equal 2**FW");
  end

  // storage itself needs no reset; reads before the first write show junk
  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) mem[wr_addr_in] <= wr_data_in;
  end

  // registered read keeps the top-level read data a flop output
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) rd_data_out <= '0;
    else rd_data_out <= mem[rd_addr_in];
  end
endmodule // flow_rec_mem

//--- verilog/rate_cap.sv
// byte cap for extra grants: token bucket refilled by 1.01 B per interval, depth 3 B
// assumes tick_in pulses once per nominal grant interval
`include "grant_sched_map.svh"
`timescale 1ns/100ps
module rate_cap (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic        tick_in,
  input  wire logic [22:0] burst_bytes_in,
  input  wire logic [15:0] grant_size_in,
  input  wire logic        fwd_valid_in,
  input  wire logic [15:0] fwd_bytes_in,
  output logic             room_out
);
  logic [25:0] tokens;
  logic [25:0] depth;
  logic [25:0] refill;
  logic [25:0] next_tokens;

  // bucket of depth 3B and rate 1.01R bounds bytes in any T by T*1.01R + 3B
  always_comb begin
    depth  = 26'(burst_bytes_in) * 26'h3;
    refill = 26'(burst_bytes_in) + 26'(burst_bytes_in / 23'(`GS_PCT_DEN));
    next_tokens = tokens;
    if (tick_in) next_tokens = (tokens + refill > depth) ? depth : tokens + refill;
    if (fwd_valid_in) begin
      next_tokens = (next_tokens > 26'(fwd_bytes_in)) ? next_tokens - 26'(fwd_bytes_in) : '0;
    end
  end

  // bucket starts empty: extra grants wait until base traffic has earned room
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) tokens <= '0;
    else tokens <= next_tokens;
  end

  // an extra grant fits only if a whole interval plus one grant is covered
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) room_out <= 1'b0;
    else room_out <= tokens >= 26'(burst_bytes_in) + 26'(grant_size_in);
  end
endmodule // rate_cap

//--- verilog/upstream_grant_scheduler.sv
// headend upstream grant scheduler for one scheduled flow, apb register slave,
// per-flow record store for every flow seen in synchronization headers.
// assumes the modem keeps its header duties and all inputs share ref_clk_in.
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`include "grant_sched_map.svh"
`timescale 1ns/100ps
module upstream_grant_scheduler #(
  parameter int FLOWS = 4,
  parameter int FW    = 2
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  reset_in,
  input  wire logic [7:0]            paddr_in,
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  input  wire logic                  hdr_valid_in,
  input  wire logic [FW-1:0]         hdr_flow_in,
  input  wire logic [7:0]            hdr_byte_in,
  input  wire logic                  fwd_valid_in,
  input  wire logic [15:0]           fwd_bytes_in,
  input  wire logic                  grant_unused_in,
  input  wire logic                  restart_req_in,
  output logic                       grant_out,
  output logic      [15:0]           grant_size_out,
  output logic                       poll_out,
  output logic      [2:0]            req_policy_out,
  output grant_sched_pkg::flow_phase_t phase_out
);
  import grant_sched_pkg::*;

  initial begin
    if (FW < 1 || FW > 3) $error("FW must be 1 to 3");
    if (FLOWS != (1 << FW)) $error("FLOWS must equal 2**FW");
  end

  // limit a requested count to the provisioned grants per interval
  function automatic logic [6:0] clamp_count(input logic [6:0] want, input logic [6:0] cap);
    clamp_count = (want > cap) ? cap : want;
  endfunction

  // software state
  logic        enable;
  sched_mode_t mode;
  logic [FW-1:0] own_flow;
  logic [15:0] grant_size;
  logic [6:0]  gpi;
  logic [23:0] grant_ivl;
  logic [23:0] poll_ivl;
  logic [7:0]  idle_limit;
  logic [FW-1:0] sel_flow;
  // scheduler state
  flow_phase_t phase;
  logic        qi;
  logic [6:0]  act_count;
  logic [23:0] ivl_cnt;
  logic [23:0] poll_cnt;
  logic [7:0]  pend;
  logic [7:0]  pct_acc;
  logic [7:0]  unused_cnt;
  logic        restart_bonus;
  logic        cap_room;
  flow_rec_t   rec_rd;
  flow_rec_t   rec_wr;
  logic [FW-1:0] rec_addr;
  // decoded terms
  logic        apb_wr;
  logic        apb_rd_phase;
  logic        own_hdr;
  logic        grants_on;
  logic        polls_on;
  logic        ivl_tick;
  logic        poll_tick;
  logic [6:0]  base_grants;
  logic        steady;
  logic [8:0]  acc_sum;
  logic        extra_due;
  logic [22:0] burst_bytes;

  // apb decode: the first access cycle raises pready at the next edge,
  // and a write lands only at the edge where psel, penable and pready meet
  assign apb_rd_phase = psel_in && penable_in && !pready_out;
  assign apb_wr       = psel_in && penable_in && pready_out && pwrite_in;
  assign own_hdr      = hdr_valid_in && (hdr_flow_in == own_flow);
  assign burst_bytes  = 23'(grant_size) * 23'(gpi);

  // which discipline is in force; activity mode runs exactly one at a time while enabled, none when disabled
  always_comb begin
    grants_on = 1'b0;
    polls_on  = 1'b0;
    case (mode)
      fixed_grant_mode:           grants_on = enable;
      realtime_poll_mode:         polls_on  = enable;
      activity_detect_grant_mode: begin
        grants_on = enable && (phase == phase_active);
        polls_on  = enable && (phase == phase_inactive);
      end
      default: begin
        grants_on = 1'b0;
        polls_on  = 1'b0;
      end
    endcase
  end

  // a timer at zero is a tick; no grant leaves in the tick cycle itself
  assign ivl_tick  = grants_on && (ivl_cnt == 24'h000000);
  assign poll_tick = polls_on && (poll_cnt == 24'h000000);

  // grants owed per interval; header count only steers activity mode
  always_comb begin
    if (mode == activity_detect_grant_mode) begin
      base_grants = clamp_count((act_count == 7'h00) ? 7'h01 : act_count, gpi);
    end else begin
      base_grants = gpi;
    end
    steady  = (mode != activity_detect_grant_mode) || (base_grants == act_count);
    acc_sum = 9'(pct_acc) + 9'(base_grants);
    extra_due = qi && (acc_sum >= 9'(`GS_PCT_DEN)) && cap_room && steady;
  end

  // apb configuration writes, one aligned word per register
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      enable     <= 1'b0;
      mode       <= fixed_grant_mode;
      own_flow   <= '0;
      grant_size <= `GS_GRANT_SIZE_RST;
      gpi        <= `GS_GPI_RST;
      grant_ivl  <= `GS_IVL_RST;
      poll_ivl   <= `GS_IVL_RST;
      idle_limit <= `GS_IDLE_RST;
      sel_flow   <= '0;
    end else if (apb_wr) begin
      case (paddr_in)
        `GS_CTRL_ADDR: begin
          enable   <= pwdata_in[`GS_CTRL_EN_BIT];
          mode     <= sched_mode_t'(pwdata_in[`GS_CTRL_MODE_LSB +: 2]);
          own_flow <= pwdata_in[`GS_CTRL_FLOW_LSB +: FW];
        end
        `GS_GRANT_CFG_ADDR: begin
          grant_size <= pwdata_in[15:0];
          gpi        <= pwdata_in[`GS_GCFG_GPI_LSB +: 7];
        end
        `GS_GRANT_IVL_ADDR:  grant_ivl  <= pwdata_in[23:0];
        `GS_POLL_IVL_ADDR:   poll_ivl   <= pwdata_in[23:0];
        `GS_IDLE_LIMIT_ADDR: idle_limit <= pwdata_in[7:0];
        `GS_FLOW_SEL_ADDR:   sel_flow   <= pwdata_in[FW-1:0];
        default: ;
      endcase
    end
  end

  // one wait state: response is registered in the first access cycle
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
    end else begin
      pready_out  <= apb_rd_phase;
      pslverr_out <= 1'b0;
      prdata_out  <= '0;
      if (apb_rd_phase) begin
        case (paddr_in)
          `GS_CTRL_ADDR: prdata_out <= 32'({own_flow, 1'b0, mode, enable});
          `GS_GRANT_CFG_ADDR:  prdata_out <= {9'h000, gpi, grant_size};
          `GS_GRANT_IVL_ADDR:  prdata_out <= {8'h00, grant_ivl};
          `GS_POLL_IVL_ADDR:   prdata_out <= {8'h00, poll_ivl};
          `GS_IDLE_LIMIT_ADDR: prdata_out <= {24'h000000, idle_limit};
          `GS_STATUS_ADDR: prdata_out <= {7'h00, unused_cnt, pend, phase, qi, act_count};
          `GS_FLOW_SEL_ADDR:   prdata_out <= 32'(sel_flow);
          `GS_FLOW_REC_ADDR:   prdata_out <= 32'(rec_rd);
          default: pslverr_out <= 1'b1; // unmapped offsets error out
        endcase
      end
    end
  end

  // last header of the scheduled flow: top bit overflow, low seven the count
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      qi        <= 1'b0;
      act_count <= 7'h00;
    end else if (own_hdr) begin
      qi        <= hdr_byte_in[`GS_HDR_QI_BIT];
      act_count <= hdr_byte_in[6:0];
    end
  end

  // activity phase; a restart request or nonzero count wins over idling
  // an own header clears the unused run, so sparse but live traffic stays active
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      phase         <= phase_active;
      unused_cnt    <= 8'h00;
      restart_bonus <= 1'b0;
    end else if (mode != activity_detect_grant_mode) begin
      phase         <= phase_active;
      unused_cnt    <= 8'h00;
      restart_bonus <= 1'b0;
    end else if (phase == phase_inactive) begin
      unused_cnt <= 8'h00;
      if (restart_req_in || (own_hdr && hdr_byte_in[6:0] != 7'h00)) begin
        phase         <= phase_active;
        restart_bonus <= 1'b1;
      end
    end else begin
      if (ivl_tick) restart_bonus <= 1'b0;
      if (own_hdr && hdr_byte_in[6:0] == 7'h00) begin
        phase <= phase_inactive;
      end else if (own_hdr) begin
        unused_cnt <= 8'h00;
      end else if (grant_unused_in) begin
        // idle_limit of zero idles out only after 256 unused grants, when the 8-bit count wraps to zero
        if (unused_cnt + 8'h01 == idle_limit) phase <= phase_inactive;
        unused_cnt <= unused_cnt + 8'h01;
      end
    end
  end

  // interval and poll timers reload on expiry and stay loaded while off
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      ivl_cnt  <= '0;
      poll_cnt <= '0;
    end else begin
      if (!grants_on || ivl_tick) ivl_cnt <= grant_ivl - 24'h000001;
      else ivl_cnt <= ivl_cnt - 24'h000001;
      if (!polls_on || poll_tick) poll_cnt <= poll_ivl - 24'h000001;
      else poll_cnt <= poll_cnt - 24'h000001;
    end
  end

  // grant budget; leftovers are dropped at the next tick so no interval overruns
  // the restart bonus rides on the first tick after a restart and is then cleared
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pend    <= 8'h00;
      pct_acc <= 8'h00;
    end else if (!grants_on) begin
      pend <= 8'h00;
    end else if (ivl_tick) begin
      pend <= 8'(base_grants) + 8'(restart_bonus) + 8'(extra_due);
      if (!qi) pct_acc <= 8'h00;
      else if (extra_due) pct_acc <= 8'(acc_sum - 9'(`GS_PCT_DEN));
      else if (acc_sum < 9'(`GS_PCT_DEN)) pct_acc <= 8'(acc_sum);
    end else if (pend != 8'h00) begin
      pend <= pend - 8'h01;
    end
  end

  // grants and polls go out as one-cycle pulses
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      grant_out      <= 1'b0;
      grant_size_out <= 16'h0000;
      poll_out       <= 1'b0;
    end else begin
      grant_out      <= grants_on && !ivl_tick && (pend != 8'h00);
      grant_size_out <= grant_size;
      poll_out       <= poll_tick;
    end
  end

  // request policy: no contention, request/data or piggyback for fixed and activity
  // realtime gets the strict policy too: its unicast polls are its only request path
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      req_policy_out <= `GS_POLICY_NO_REQ;
      phase_out      <= phase_active;
    end else begin
      req_policy_out <= (mode == fixed_grant_mode || mode == activity_detect_grant_mode ||
                         mode == realtime_poll_mode) ? `GS_POLICY_NO_REQ : 3'h0;
      phase_out      <= phase;
    end
  end

  // record store: headers of any flow, otherwise the scheduled flow's own state
  always_comb begin
    rec_addr     = hdr_valid_in ? hdr_flow_in : own_flow;
    rec_wr.mode  = nonrealtime_poll_mode;
    rec_wr.phase = phase_inactive;
    rec_wr.qi    = qi;
    rec_wr.count = act_count;
    if (hdr_valid_in) begin
      rec_wr.qi    = hdr_byte_in[`GS_HDR_QI_BIT];
      rec_wr.count = hdr_byte_in[6:0];
    end
    if (rec_addr == own_flow) begin
      rec_wr.mode  = mode;
      rec_wr.phase = phase;
    end
  end

  // written every cycle: the header's flow if one arrived, else the own flow
  flow_rec_mem #(.FLOWS(FLOWS), .FW(FW)) u_rec (
    .ref_clk_in  (ref_clk_in),
    .reset_in    (reset_in),
    .wr_en_in    (1'b1),
    .wr_addr_in  (rec_addr),
    .wr_data_in  (rec_wr),
    .rd_addr_in  (sel_flow),
    .rd_data_out (rec_rd)
  );

  // only extra grants wait for bucket room; base grants are never held back
  rate_cap u_cap (
    .ref_clk_in     (ref_clk_in),
    .reset_in       (reset_in),
    .tick_in        (ivl_tick),
    .burst_bytes_in (burst_bytes),
    .grant_size_in  (grant_size),
    .fwd_valid_in   (fwd_valid_in),
    .fwd_bytes_in   (fwd_bytes_in),
    .room_out       (cap_room)
  );
endmodule // upstream_grant_scheduler

//--- test/grant_sched_sva.sv
// port checker for the grant scheduler: apb timing, reset, policy, polls
// assumes one clock, sync active-high reset, bound to the top module
`include "grant_sched_map.svh"
`timescale 1ns/100ps
module grant_sched_checker (
  input wire logic                         ref_clk_in,
  input wire logic                         reset_in,
  input wire logic [7:0]                   paddr_in,
  input wire logic                         psel_in,
  input wire logic                         penable_in,
  input wire logic                         pwrite_in,
  input wire logic [31:0]                  pwdata_in,
  input wire logic [31:0]                  prdata_out,
  input wire logic                         pready_out,
  input wire logic                         pslverr_out,
  input wire logic                         poll_out,
  input wire logic [2:0]                   req_policy_out,
  input wire grant_sched_pkg::flow_phase_t phase_out
);
  import grant_sched_pkg::*;
  logic [1:0] mode_q;
  logic [1:0] settle;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // mirror of the mode field; settle lets in-flight pulses drain after a change
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      mode_q <= 2'h0;
      settle <= 2'h0;
    end else if (psel_in && penable_in && pready_out && pwrite_in
                 && paddr_in == `GS_CTRL_ADDR) begin
      mode_q <= pwdata_in[2:1];
      settle <= 2'h0;
    end else if (settle != 2'h3) begin
      settle <= settle + 2'h1;
    end
  end
  apb_wait_a: assert property ($rose(penable_in) && psel_in |-> !pready_out ##1 pready_out)
    else $error("pready not one cycle after access start");
  ready_access_a: assert property (pready_out |-> psel_in && penable_in && $past(penable_in))
    else $error("pready outside an access phase");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data not zero while idle");
  reset_vals_a: assert property ($past(reset_in) |-> !poll_out && req_policy_out == 3'h7
                                 && phase_out == phase_active)
    else $error("outputs wrong after reset");
  policy_a: assert property (settle == 2'h3 |->
                             req_policy_out == (mode_q == 2'h3 ? 3'h0 : 3'h7))
    else $error("request policy does not match mode");
  fixed_no_poll_a: assert property (settle == 2'h3 && mode_q == 2'h0 |-> !poll_out)
    else $error("poll issued in fixed mode");
  active_no_poll_a: assert property ((phase_out == phase_active)[*3] ##0
                                     (settle == 2'h3 && mode_q == 2'h2) |-> !poll_out)
    else $error("poll issued while flow active");
endmodule // grant_sched_checker

bind upstream_grant_scheduler grant_sched_checker chk_i (.ref_clk_in(ref_clk_in),
  .reset_in(reset_in), .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .poll_out(poll_out),
  .req_policy_out(req_policy_out), .phase_out(phase_out));

//--- test/modem_tx_model.sv
// modem transmit side: answers grants with data or unused marks, polls with restarts
// assumes scheduler pulses on ref_clk_in; traffic state comes from the bench
`timescale 1ns/100ps
module modem_tx_model (
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  input  wire logic        grant_in,
  input  wire logic [15:0] size_in,
  input  wire logic        poll_in,
  input  wire logic        busy_in,
  input  wire logic        over_in,
  input  wire logic [6:0]  need_in,
  input  wire logic        zero_pkt_in,
  output logic             hdr_valid_out,
  output logic [7:0]       hdr_byte_out,
  output logic             fwd_valid_out,
  output logic [15:0]      fwd_bytes_out,
  output logic             unused_out,
  output logic             restart_out
);
  logic zero_sent;
  // no contention or piggyback request path exists here
  always_ff @(posedge ref_clk_in) begin
    hdr_valid_out <= 1'h0;
    fwd_valid_out <= 1'h0;
    unused_out <= 1'h0;
    restart_out <= 1'h0;
    hdr_byte_out <= ~hdr_byte_out;  // stale bytes keep moving, never trusted
    fwd_bytes_out <= ~fwd_bytes_out;
    if (reset_in) begin
      zero_sent <= 1'h0;
      hdr_byte_out <= 8'h00;
      fwd_bytes_out <= 16'h0000;
    end else if (grant_in && busy_in) begin
      hdr_valid_out <= 1'h1;
      hdr_byte_out <= {over_in, need_in};
      fwd_valid_out <= 1'h1;
      fwd_bytes_out <= size_in;
      zero_sent <= 1'h0;
    end else if (grant_in && zero_pkt_in && !zero_sent) begin
      hdr_valid_out <= 1'h1;
      hdr_byte_out <= {over_in, 7'h00};
      zero_sent <= 1'h1;
    end else if (grant_in) begin
      unused_out <= 1'h1;
    end
    // a poll while traffic waits asks for the grants back
    if (!reset_in && poll_in && busy_in) begin
      restart_out <= 1'h1;
    end
  end
endmodule // modem_tx_model

//--- test/upstream_grant_scheduler_tb_top.sv
// self-checking bench: register rows, then fixed, polled and activity scenarios
// assumes the modem model beside the scheduler and a 25 MHz clock
`timescale 1ns/100ps
module upstream_grant_scheduler_tb_top;
  import grant_sched_pkg::*;
  typedef struct {logic [7:0] a; bit w; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, hdr_valid, fwd_valid;
  logic unused, restart, grant, poll, busy, over, zero_pkt;
  logic [7:0] paddr, hdr_byte;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] fwd_bytes, gsize;
  logic [6:0] need;
  logic [2:0] policy;
  logic [1:0] hflow;
  logic er;
  flow_phase_t phase;
  int bad_count, checks_done, g, p;
  row_t rows [12] = '{
    '{8'h04, 1'h0, 32'h0, 32'h0001_0000, 1'h0}, '{8'h08, 1'h0, 32'h0, 32'h3e8, 1'h0},
    '{8'h0c, 1'h0, 32'h0, 32'h3e8, 1'h0}, '{8'h10, 1'h0, 32'h0, 32'h4, 1'h0},
    '{8'h20, 1'h0, 32'h0, 32'h0, 1'h1}, '{8'h20, 1'h1, 32'h5, 32'h0, 1'h1},
    '{8'h08, 1'h1, 32'h14, 32'h0, 1'h0}, '{8'h08, 1'h0, 32'h0, 32'h14, 1'h0},
    '{8'h0c, 1'h1, 32'h14, 32'h0, 1'h0}, '{8'h04, 1'h1, 32'h0003_0040, 32'h0, 1'h0},
    '{8'h04, 1'h0, 32'h0, 32'h0003_0040, 1'h0}, '{8'h14, 1'h1, 32'hffff, 32'h0, 1'h0}};

  upstream_grant_scheduler #(.FLOWS(4), .FW(2)) DUT (.ref_clk_in(clk), .reset_in(rst),
    .paddr_in(paddr), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .hdr_valid_in(hdr_valid), .hdr_flow_in(hflow), .hdr_byte_in(hdr_byte),
    .fwd_valid_in(fwd_valid), .fwd_bytes_in(fwd_bytes), .grant_unused_in(unused),
    .restart_req_in(restart), .grant_out(grant), .grant_size_out(gsize), .poll_out(poll),
    .req_policy_out(policy), .phase_out(phase));
  modem_tx_model modem (.ref_clk_in(clk), .reset_in(rst), .grant_in(grant), .size_in(gsize),
    .poll_in(poll), .busy_in(busy), .over_in(over), .need_in(need), .zero_pkt_in(zero_pkt),
    .hdr_valid_out(hdr_valid), .hdr_byte_out(hdr_byte), .fwd_valid_out(fwd_valid),
    .fwd_bytes_out(fwd_bytes), .unused_out(unused), .restart_out(restart));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      bad_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  // apb master: request held until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input bit w, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    er = pslverr;
    chk(n < 20, "apb answer missing");
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic ctrl(input logic [1:0] m);
    apb(8'h00, 1'h1, {26'h0, 2'h1, 1'h0, m, 1'h1});  // own flow 1, enabled
  endtask
  // counts grant and poll pulses; periodic pulses give exact counts over 80 cycles
  task automatic cnt(input int n);
    g = 0;
    p = 0;
    repeat (n) begin
      @(posedge clk);
      g += int'(grant === 1'h1);
      p += int'(poll === 1'h1);
    end
  endtask
  task automatic wait_ph(input flow_phase_t v, input int lim);
    int n;
    n = 0;
    while (phase !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(phase === v, "phase did not change in time");
  endtask

  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // watchdog: the whole sequence needs about 2800 cycles
  initial begin
    repeat (8000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial begin
    {rst, busy} = 2'h3;
    {psel, penable, pwrite, over, zero_pkt, paddr, pwdata} = 45'h0;
    hflow = 2'h1;
    need = 7'h2;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      chk(er === rows[i].e, "error response");
      if (!rows[i].w) begin
        chk(rd === rows[i].x, "read data");
      end
    end
    // fixed mode: three grants an interval, header count of two ignored
    ctrl(2'h0);
    repeat (30) @(posedge clk);
    cnt(80);
    chk(g === 12 && p === 0, "fixed grants");
    chk(gsize === 16'h0040, "grant size");
    // headers tagged with another flow: own grants go on, record kept apart
    hflow <= 2'h2;
    cnt(40);
    chk(g === 6, "grants with foreign headers");
    hflow <= 2'h1;
    over <= 1'h1;
    cnt(2000);
    chk(g >= 300 && g <= 303, "overflow extra grants");
    over <= 1'h0;
    for (int m = 0; m < 4; m++) begin
      ctrl(m[1:0]);
      repeat (3) @(posedge clk);
      chk(policy === (m == 3 ? 3'h0 : 3'h7), "request policy");
    end
    ctrl(2'h1);
    repeat (30) @(posedge clk);
    cnt(80);
    chk(p === 4 && g === 0, "realtime polls");
    // activity mode: two grants while busy, polls once idle
    ctrl(2'h2);
    wait_ph(phase_active, 100);
    repeat (60) @(posedge clk);
    cnt(80);
    chk(g === 8 && p === 0, "active grants");
    busy <= 1'h0;
    wait_ph(phase_inactive, 200);
    repeat (40) @(posedge clk);
    cnt(80);
    chk(p === 4 && g === 0, "inactive polls");
    busy <= 1'h1;
    wait_ph(phase_active, 60);
    g = 0;
    while (grant !== 1'h1 && g < 40) begin
      @(posedge clk);
      g++;
    end
    cnt(15);
    chk(g === 2, "restart bonus grant");
    busy <= 1'h0;
    zero_pkt <= 1'h1;
    wait_ph(phase_inactive, 25);
    apb(8'h18, 1'h1, 32'h1);
    apb(8'h1c, 1'h0, 32'h0);
    chk(rd === 32'h0000_0400, "flow record");
    apb(8'h18, 1'h1, 32'h2);
    apb(8'h1c, 1'h0, 32'h0);
    chk(rd === 32'h0000_0602, "other flow record");
    // mid-run reset: outputs back to idle values, control cleared
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(policy === 3'h7 && phase === phase_active && poll === 1'h0, "reset outputs");
    chk(grant === 1'h0 && gsize === 16'h0000 && pready === 1'h0, "reset grants");
    apb(8'h00, 1'h0, 32'h0);
    chk(rd === 32'h0 && er === 1'h0, "control after reset");
    complete_run();
  end
endmodule // upstream_grant_scheduler_tb_top
